/* receiver_mode_command_engine_tb_top.sv */
`timescale 1ns/1ps
`include "rmce_regs.svh"
module receiver_mode_command_engine_tb_top;
    localparam int STEP = 4;
    localparam int SETC = 8;
    localparam int GATE = 16;
    localparam logic [15:0] BASE = 16'h0064;
    localparam logic [15:0] INCR = 16'h0064;

    typedef struct packed {
        logic [31:0] d;
        logic e;
    } rmce_note_s;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic am_edge = 1'b0;
    logic fc_on = 1'b1;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [2:0] dgl_tc_sel_o;
    logic [2:0] discrete_agc_tc_sel_o;
    logic [15:0] agc_tc_mult_o;
    logic [6:0] am_gain_pos_o;
    logic [6:0] am_level_o;
    logic busy_o;
    int miscompares = 0;
    int samples_checked = 0;
    rmce_note_s notes[$];

    always #2.5 mclk = ~mclk;

    // One pulse every other cycle: half the gate length per window
    always @(posedge mclk) begin
        am_edge <= fc_on ? ~am_edge : 1'b0;
    end

    rmce_top #(
        .GAIN_STEP_CYC(STEP),
        .GAIN_SET_CYC(SETC),
        .FC_GATE_CYC(GATE),
        .LPF_BASE(BASE),
        .LPF_STEP(INCR)
    ) uut (
        .mclk_i(mclk),
        .rst_i(rst),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .pstrb_i(pstrb),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .am_edge_i(am_edge),
        .dgl_tc_sel_o(dgl_tc_sel_o),
        .discrete_agc_tc_sel_o(discrete_agc_tc_sel_o),
        .agc_tc_mult_o(agc_tc_mult_o),
        .am_gain_pos_o(am_gain_pos_o),
        .am_level_o(am_level_o),
        .busy_o(busy_o)
    );

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("miscompares=%0d samples_checked=%0d", miscompares,
                 samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Read results are compared when the access phase completes
    always @(posedge mclk) begin
        if (psel && penable && pready_o === 1'b1 && !pwrite) begin
            if (notes.size() == 0) begin
                miscompares++;
                $display("MISMATCH t=%0t read without a note", $time);
            end else begin
                chk(prdata_o, notes[0].d);
                chk(32'(pslverr_o), 32'(notes[0].e));
                void'(notes.pop_front());
            end
        end
    end

    task xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
              input logic [7:0] exp, input logic err);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {6'h00, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        if (!wr) notes.push_back('{{24'h000000, exp}, err});
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        if (k >= 50) begin
            miscompares++;
            stop_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [3:0] idx, input logic [7:0] wd);
        xfer(1'b1, idx, wd, 8'h00, 1'b0);
    endtask

    task rd(input logic [3:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00, exp, 1'b0);
    endtask

    // Cycles that busy stays high after a trigger; 0 if it never rises
    task run(output int cyc);
        int k;
        k = 0;
        cyc = 0;
        #1;
        while (busy_o !== 1'b1 && k < 4) begin
            @(posedge mclk);
            #1;
            k++;
        end
        while (busy_o === 1'b1 && cyc < 200) begin
            @(posedge mclk);
            #1;
            cyc++;
        end
    endtask

    task gain(input logic [1:0] code, input int lo);
        int c;
        wr(`RMCE_IDX_GAIN_CTL, {1'b1, 5'h00, code});
        run(c);
        chk(32'(c >= lo && c <= lo + 3), 32'h1);
    endtask

    initial begin
        logic [3:0] regs[6];
        logic [15:0] mult[4];
        logic [15:0] corner;
        logic [7:0] idx;
        logic [6:0] tgt;
        int c;
        regs = '{`RMCE_IDX_AGC_CTL, `RMCE_IDX_GAIN_CTL, `RMCE_IDX_MODE,
                 `RMCE_IDX_WORD1, `RMCE_IDX_WORD2, `RMCE_IDX_WORD3};
        void'($urandom(68));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        foreach (regs[i]) rd(regs[i], `RMCE_BYTE_RST);
        xfer(1'b0, 4'hF, 8'h00, 8'h00, 1'b1);
        chk(32'(am_gain_pos_o), 32'h0);
        chk(32'(am_level_o), 32'h63);
        // Filter corner table lookups, both index limits included
        wr(`RMCE_IDX_MODE, {`RMCE_MODE_LPF_TABLE, 3'h0});
        rd(`RMCE_IDX_MODE, {`RMCE_MODE_LPF_TABLE, 3'h0});
        for (int i = 0; i < 4; i++) begin
            idx = (i == 0) ? 8'h00 : (i == 1) ? 8'h1F
                : 8'($urandom_range(30, 1));
            corner = BASE + INCR * 16'(idx);
            rd(`RMCE_IDX_MODE, {`RMCE_MODE_LPF_TABLE, 3'h0});
            wr(`RMCE_IDX_WORD2, idx);
            wr(`RMCE_IDX_WORD1, 8'($urandom));
            run(c);
            chk(32'(c), 32'h1);
            rd(`RMCE_IDX_WORD1, idx);
            rd(`RMCE_IDX_WORD2, corner[7:0]);
            rd(`RMCE_IDX_WORD3, corner[15:8]);
        end
        // Frequency capture, with AM edges running and then with edges stopped
        wr(`RMCE_IDX_MODE, {`RMCE_MODE_FREQ_CNT, 3'h0});
        rd(`RMCE_IDX_MODE, {`RMCE_MODE_FREQ_CNT, 3'h0});
        for (int i = 0; i < 2; i++) begin
            if (i == 1) begin
                fc_on <= 1'b0;
                repeat (3 * GATE) @(posedge mclk);
            end
            wr(`RMCE_IDX_WORD1, 8'($urandom));
            run(c);
            chk(32'(c), 32'h1);
            rd(`RMCE_IDX_WORD1, (i == 0) ? 8'(GATE / 2) : 8'h00);
            rd(`RMCE_IDX_WORD2, 8'h00);
            rd(`RMCE_IDX_WORD3, 8'h00);
        end
        // Trigger in a mode this block does not serve is refused
        wr(`RMCE_IDX_MODE, 8'h18);
        wr(`RMCE_IDX_WORD1, 8'h00);
        run(c);
        chk(32'(c), 32'h0);
        // Gain: floor, set, ceiling, step down
        gain(`RMCE_GCMD_DEC, STEP);
        chk(32'(am_gain_pos_o), 32'h0);
        rd(`RMCE_IDX_GAIN_CTL, {6'h00, `RMCE_GCMD_DEC});
        wr(`RMCE_IDX_WORD2, 8'd98);
        gain(`RMCE_GCMD_SET, SETC);
        chk(32'(am_gain_pos_o), 32'd98);
        for (int j = 0; j < 2; j++) begin
            gain(`RMCE_GCMD_INC, STEP);
            chk(32'(am_gain_pos_o), 32'(`RMCE_GAIN_MAX));
            chk(32'(am_level_o), 32'h0);
        end
        gain(`RMCE_GCMD_DEC, STEP);
        chk(32'(am_gain_pos_o), 32'h62);
        gain(2'h3, STEP);
        chk(32'(am_gain_pos_o), 32'h62);
        // Update during a running set is ignored
        tgt = 7'($urandom_range(97, 1));
        wr(`RMCE_IDX_WORD2, {1'b0, tgt});
        wr(`RMCE_IDX_GAIN_CTL, {1'b1, 5'h00, `RMCE_GCMD_SET});
        wr(`RMCE_IDX_GAIN_CTL, {1'b1, 5'h00, `RMCE_GCMD_INC});
        run(c);
        chk(32'(am_gain_pos_o), 32'(tgt));
        chk(32'(am_level_o), 32'(7'd99 - tgt));
        // Custom time constants, zero multiplier stored as one
        wr(`RMCE_IDX_MODE, {`RMCE_MODE_CUSTOM_TC, 3'h0});
        for (int d = 1; d < 4; d++) begin
            mult[d] = (d == 3) ? 16'h0000 : 16'($urandom_range(65535, 1));
            wr(`RMCE_IDX_WORD3, mult[d][15:8]);
            wr(`RMCE_IDX_WORD2, mult[d][7:0]);
            wr(`RMCE_IDX_WORD1, 8'(d));
            run(c);
            chk(32'(c), 32'h1);
        end
        // Designator above 3 leaves every slot alone
        wr(`RMCE_IDX_WORD1, 8'($urandom_range(255, 4)));
        run(c);
        chk(32'(c), 32'h1);
        for (int s = 0; s < 8; s++) begin
            wr(`RMCE_IDX_AGC_CTL, 8'(s));
            repeat (2) @(posedge mclk);
            #1;
            chk(32'(dgl_tc_sel_o), 32'(s));
            chk(32'(discrete_agc_tc_sel_o), 32'(s));
            chk(32'(agc_tc_mult_o), (s < 5) ? 32'h0 :
                (mult[s - 4] == 16'h0000) ? 32'h1 : 32'(mult[s - 4]));
            rd(`RMCE_IDX_AGC_CTL, 8'(s));
        end
        stop_test;
    end

    initial begin
        #200000;
        miscompares++;
        stop_test;
    end
endmodule

/* rmce_gain.sv */
`timescale 1ns/1ps
`include "rmce_regs.svh"
module rmce_gain
    import rmce_pkg::*;
#(
    parameter int STEP_CYC = `RMCE_GAIN_STEP_CYC,
    parameter int SET_CYC = `RMCE_GAIN_SET_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Command side
    rmce_gain_if.pot g
);

    rmce_gain_s s;
    rmce_gain_s n;

    always_comb begin
        n = s;
        case (s.state)
            RMCE_G_IDLE: begin
                if (g.go) begin
                    n.state = RMCE_G_WAIT;
                    n.cmd = g.cmd;
                    n.target = g.target;
                    // Full-scale set and single step have own times
                    if (g.cmd == `RMCE_GCMD_SET) begin
                        n.cnt = 32'(SET_CYC - 1);
                    end else begin
                        n.cnt = 32'(STEP_CYC - 1);
                    end
                end
            end
            RMCE_G_WAIT: begin
                if (s.cnt == 32'h0) begin
                    n.state = RMCE_G_APPLY;
                end else begin
                    n.cnt = s.cnt - 32'h1;
                end
            end
            RMCE_G_APPLY: begin
                n.state = RMCE_G_IDLE;
                case (s.cmd)
                    `RMCE_GCMD_DEC: begin
                        if (s.pos != 7'h00) begin
                            n.pos = s.pos - 7'h01;
                        end
                    end
                    `RMCE_GCMD_INC: begin
                        if (s.pos < `RMCE_GAIN_MAX) begin
                            n.pos = s.pos + 7'h01;
                        end
                    end
                    `RMCE_GCMD_SET: begin
                        if (s.target > `RMCE_GAIN_MAX) begin
                            n.pos = `RMCE_GAIN_MAX;
                        end else begin
                            n.pos = s.target;
                        end
                    end
                    default: begin
                        n.pos = s.pos;
                    end
                endcase
            end
            default: begin
                n.state = RMCE_G_IDLE;
            end
        endcase
        // Lower position gives higher amplitude
        n.level = `RMCE_GAIN_MAX - n.pos;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s <= '{state: RMCE_G_IDLE, cmd: 2'h0, target: 7'h00,
                   cnt: 32'h0, pos: `RMCE_GAIN_POS_RST,
                   level: `RMCE_GAIN_MAX - `RMCE_GAIN_POS_RST};
        end else begin
            s <= n;
        end
    end

    assign g.busy = (s.state != RMCE_G_IDLE);
    assign g.pos = s.pos;
    assign g.level = s.level;

    pos_bound_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        s.pos <= `RMCE_GAIN_MAX)
        else $error("gain position above top step");

    step_inc_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s.state == RMCE_G_APPLY && s.cmd == `RMCE_GCMD_INC) |=>
        s.pos == (($past(s.pos) == `RMCE_GAIN_MAX) ? `RMCE_GAIN_MAX
                  : $past(s.pos) + 7'h01))
        else $error("increment step wrong");

    step_dec_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s.state == RMCE_G_APPLY && s.cmd == `RMCE_GCMD_DEC
         && s.pos != 7'h00) |=> s.pos == $past(s.pos) - 7'h01)
        else $error("decrement step wrong");

    level_inv_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s.level + s.pos) == `RMCE_GAIN_MAX)
        else $error("amplitude not inverse of position");

    go_busy_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (g.go && s.state == RMCE_G_IDLE) |=> g.busy [*2])
        else $error("busy not held after gain launch");

endmodule

/* rmce_gain_if.sv */
`timescale 1ns/1ps
interface rmce_gain_if;
    logic go;
    logic [1:0] cmd;
    logic [6:0] target;
    logic busy;
    logic [6:0] pos;
    logic [6:0] level;

    modport ctl (output go, output cmd, output target,
                 input busy, input pos, input level);
    modport pot (input go, input cmd, input target,
                 output busy, output pos, output level);
endinterface

/* rmce_pkg.sv */
package rmce_pkg;

    typedef logic [7:0] rmce_byte_t;

    typedef enum logic [0:0] {
        RMCE_IDLE = 1'b0,
        RMCE_EXEC = 1'b1
    } rmce_eng_e;

    typedef enum logic [1:0] {
        RMCE_G_IDLE = 2'b00,
        RMCE_G_WAIT = 2'b01,
        RMCE_G_APPLY = 2'b11
    } rmce_gain_e;

    typedef struct packed {
        rmce_eng_e state;
        logic [4:0] op;
        rmce_byte_t arg;
        rmce_byte_t agc_ctl;
        rmce_byte_t gain_ctl;
        rmce_byte_t mode_ctl;
        rmce_byte_t cmd2;
        rmce_byte_t cmd3;
        rmce_byte_t res1;
        rmce_byte_t res2;
        rmce_byte_t res3;
        logic [2:0][15:0] tc_mult;
        logic [15:0] tc_out;
        logic [23:0] fc_cnt;
        logic [23:0] fc_latch;
        logic [31:0] gate_cnt;
        logic [31:0] prdata;
        logic gain_go;
    } rmce_top_s;

    typedef struct packed {
        rmce_gain_e state;
        logic [1:0] cmd;
        logic [6:0] target;
        logic [31:0] cnt;
        logic [6:0] pos;
        logic [6:0] level;
    } rmce_gain_s;

endpackage

/* rmce_regs.svh */
`ifndef RMCE_REGS_SVH
`define RMCE_REGS_SVH

// Register indexes; byte address is four times the index
`define RMCE_IDX_AGC_CTL 4'h2
`define RMCE_IDX_GAIN_CTL 4'h4
`define RMCE_IDX_MODE 4'h6
`define RMCE_IDX_WORD1 4'h7
`define RMCE_IDX_WORD2 4'h8
`define RMCE_IDX_WORD3 4'h9

// Field positions
`define RMCE_MODE_LSB 3
`define RMCE_BUSY_BIT 0
`define RMCE_GAIN_UPDATE_BIT 7

// Mode codes
`define RMCE_MODE_LPF_TABLE 5'h06
`define RMCE_MODE_FREQ_CNT 5'h07
`define RMCE_MODE_CUSTOM_TC 5'h0A

// Gain command codes and range
`define RMCE_GCMD_DEC 2'h0
`define RMCE_GCMD_INC 2'h1
`define RMCE_GCMD_SET 2'h2
`define RMCE_GAIN_MAX 7'h63
`define RMCE_GAIN_POS_RST 7'h00

// First custom time constant slot, designators 1 to 3
`define RMCE_CUSTOM_TC_BASE 3'h5
`define RMCE_CUSTOM_DES_MAX 8'h03

// Reset values
`define RMCE_BYTE_RST 8'h00

// Timing
`define RMCE_CLK_MHZ 200
`define RMCE_GAIN_STEP_US 200
`define RMCE_GAIN_STEP_CYC (`RMCE_GAIN_STEP_US * `RMCE_CLK_MHZ)
`define RMCE_GAIN_SET_MS 40
`define RMCE_GAIN_SET_CYC (`RMCE_GAIN_SET_MS * 1000 * `RMCE_CLK_MHZ)
`define RMCE_FC_GATE_MS 1000
`define RMCE_FC_GATE_CYC (`RMCE_FC_GATE_MS * 1000 * `RMCE_CLK_MHZ)

`endif

/* rmce_top.sv */
`timescale 1ns/1ps
`include "rmce_regs.svh"
// How it works
// - Mode 00110 selects filter corner table read
// - Word one write starts table lookup
// - Corner low, high in words two, three
// - Mode 00111 selects frequency counter read
// - Word one write captures frequency count
// - Count bytes low to high in words
// - Count refreshed once per second
// - Counter runs in every mode
// - Hundred gain positions, no readback
// - Gain code 0 decrements, 1 increments
// - Gain code 2 sets position from word
// - Step 200 us, set 40 ms, busy
// - Gain position saturates at 99
// - Lower position gives higher amplitude
// - Low three bits pick time constant
// - Three custom time constants via mode
module rmce_top
    import rmce_pkg::*;
#(
    parameter int GAIN_STEP_CYC = `RMCE_GAIN_STEP_CYC,
    parameter int GAIN_SET_CYC = `RMCE_GAIN_SET_CYC,
    parameter int FC_GATE_CYC = `RMCE_FC_GATE_CYC,
    parameter logic [15:0] LPF_BASE = 16'h0064,
    parameter logic [15:0] LPF_STEP = 16'h0064
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // AM signal cycle marker
    input wire logic am_edge_i,
    // Time constant selection
    output logic [2:0] dgl_tc_sel_o,
    output logic [2:0] discrete_agc_tc_sel_o,
    output logic [15:0] agc_tc_mult_o,
    // AM output gain
    output logic [6:0] am_gain_pos_o,
    output logic [6:0] am_level_o,
    // Status
    output logic busy_o
);

    rmce_top_s s;
    rmce_top_s n;

    rmce_gain_if gif ();

    rmce_gain #(
        .STEP_CYC(GAIN_STEP_CYC),
        .SET_CYC(GAIN_SET_CYC)
    ) u_gain (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .g(gif.pot)
    );

    function automatic logic is_mapped(input logic [3:0] idx);
        case (idx)
            `RMCE_IDX_AGC_CTL,
            `RMCE_IDX_GAIN_CTL,
            `RMCE_IDX_MODE,
            `RMCE_IDX_WORD1,
            `RMCE_IDX_WORD2,
            `RMCE_IDX_WORD3: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] lpf_corner(input logic [4:0] idx);
        lpf_corner = 16'(LPF_BASE + LPF_STEP * {11'h000, idx});
    endfunction

    function automatic logic is_cmd_mode(input logic [4:0] m);
        is_cmd_mode = (m == `RMCE_MODE_LPF_TABLE) ||
                      (m == `RMCE_MODE_FREQ_CNT) ||
                      (m == `RMCE_MODE_CUSTOM_TC);
    endfunction

    logic [3:0] idx;
    logic mapped;
    logic wr;
    logic rd_setup;
    logic [4:0] mode;
    logic trig_ok;
    logic gain_trig;
    logic gate_tick;
    logic [1:0] slot;
    logic [15:0] mult_in;
    logic [7:0] status;

    assign idx = paddr_i[5:2];
    assign mapped = (paddr_i[11:6] == 6'h00) && (paddr_i[1:0] == 2'h0)
                    && is_mapped(paddr_i[5:2]);
    assign wr = psel_i && penable_i && pwrite_i && pstrb_i[0] && mapped;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign mode = s.mode_ctl[7:`RMCE_MODE_LSB];
    assign trig_ok = wr && idx == `RMCE_IDX_WORD1 && !busy_o
                     && is_cmd_mode(mode);
    assign gain_trig = wr && idx == `RMCE_IDX_GAIN_CTL && !busy_o
                       && pwdata_i[`RMCE_GAIN_UPDATE_BIT];
    assign gate_tick = (s.gate_cnt == 32'h0);
    assign slot = 2'(s.arg - 8'h01);
    assign mult_in = ({s.cmd3, s.cmd2} == 16'h0000) ? 16'h0001
                     : {s.cmd3, s.cmd2};
    assign status = {s.mode_ctl[7:`RMCE_MODE_LSB], 2'b00, busy_o};

    always_comb begin
        n = s;
        n.gain_go = gain_trig;
        // Register writes
        if (wr) begin
            case (idx)
                `RMCE_IDX_AGC_CTL: n.agc_ctl = pwdata_i[7:0];
                `RMCE_IDX_GAIN_CTL: begin
                    // Update bit is never stored, taken or not; it reads back as zero
                    n.gain_ctl = {1'b0, pwdata_i[6:0]};
                end
                `RMCE_IDX_MODE: n.mode_ctl = pwdata_i[7:0];
                `RMCE_IDX_WORD2: n.cmd2 = pwdata_i[7:0];
                `RMCE_IDX_WORD3: n.cmd3 = pwdata_i[7:0];
                default: n.agc_ctl = s.agc_ctl;
            endcase
        end
        // Command engine
        case (s.state)
            RMCE_IDLE: begin
                if (trig_ok) begin
                    n.state = RMCE_EXEC;
                    n.op = mode;
                    n.arg = pwdata_i[7:0];
                end
            end
            RMCE_EXEC: begin
                n.state = RMCE_IDLE;
                case (s.op)
                    `RMCE_MODE_LPF_TABLE: begin
                        n.res1 = s.cmd2;
                        {n.res3, n.res2} = lpf_corner(s.cmd2[4:0]);
                    end
                    `RMCE_MODE_FREQ_CNT: begin
                        {n.res3, n.res2, n.res1} = s.fc_latch;
                    end
                    `RMCE_MODE_CUSTOM_TC: begin
                        if (s.arg != 8'h00 &&
                            s.arg <= `RMCE_CUSTOM_DES_MAX) begin
                            n.tc_mult[slot] = mult_in;
                        end
                    end
                    default: n.op = s.op;
                endcase
            end
            default: n.state = RMCE_IDLE;
        endcase
        // Free-running frequency counter, gated each second
        if (gate_tick) begin
            n.gate_cnt = 32'(FC_GATE_CYC - 1);
            n.fc_latch = s.fc_cnt;
            n.fc_cnt = am_edge_i ? 24'h000001 : 24'h000000;
        end else begin
            n.gate_cnt = s.gate_cnt - 32'h1;
            if (am_edge_i && s.fc_cnt != 24'hFFFFFF) begin
                n.fc_cnt = s.fc_cnt + 24'h000001;
            end
        end
        // Custom slots carry a programmed multiplier
        if (n.agc_ctl[2:0] >= `RMCE_CUSTOM_TC_BASE) begin
            n.tc_out = n.tc_mult[2'(n.agc_ctl[2:0] -
                                    `RMCE_CUSTOM_TC_BASE)];
        end else begin
            n.tc_out = 16'h0000;
        end
        // Read data captured in the setup phase
        if (rd_setup) begin
            n.prdata = 32'h0;
            if (mapped) begin
                case (idx)
                    `RMCE_IDX_AGC_CTL: n.prdata[7:0] = s.agc_ctl;
                    // Gain position has no readback
                    `RMCE_IDX_GAIN_CTL: n.prdata[7:0] = s.gain_ctl;
                    `RMCE_IDX_MODE: n.prdata[7:0] = status;
                    `RMCE_IDX_WORD1: n.prdata[7:0] = s.res1;
                    `RMCE_IDX_WORD2: n.prdata[7:0] = s.res2;
                    `RMCE_IDX_WORD3: n.prdata[7:0] = s.res3;
                    default: n.prdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s <= '{state: RMCE_IDLE, op: 5'h00, arg: `RMCE_BYTE_RST,
                   agc_ctl: `RMCE_BYTE_RST, gain_ctl: `RMCE_BYTE_RST,
                   mode_ctl: `RMCE_BYTE_RST, cmd2: `RMCE_BYTE_RST,
                   cmd3: `RMCE_BYTE_RST, res1: `RMCE_BYTE_RST,
                   res2: `RMCE_BYTE_RST, res3: `RMCE_BYTE_RST,
                   tc_mult: '0, tc_out: 16'h0000, fc_cnt: 24'h000000,
                   fc_latch: 24'h000000, gate_cnt: 32'h0,
                   prdata: 32'h0, gain_go: 1'b0};
        end else begin
            s <= n;
        end
    end

    assign gif.go = s.gain_go;
    assign gif.cmd = s.gain_ctl[1:0];
    assign gif.target = s.cmd2[6:0];

    assign busy_o = (s.state != RMCE_IDLE) || s.gain_go || gif.busy;
    assign prdata_o = s.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;

    assign dgl_tc_sel_o = s.agc_ctl[2:0];
    assign discrete_agc_tc_sel_o = s.agc_ctl[2:0];
    assign agc_tc_mult_o = s.tc_out;
    assign am_gain_pos_o = gif.pos;
    assign am_level_o = gif.level;

    busy_on_trig_a: assert property (@(posedge mclk_i)
        disable iff (rst_i) trig_ok |=> busy_o)
        else $error("busy missing after trigger");

    exec_once_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s.state == RMCE_EXEC && !s.gain_go && !gif.busy) |=>
        !busy_o || $past(gain_trig))
        else $error("busy stuck after command");

    lpf_result_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s.state == RMCE_EXEC && s.op == `RMCE_MODE_LPF_TABLE) |=>
        (s.res1 == $past(s.cmd2)) &&
        ({s.res3, s.res2} == lpf_corner($past(s.cmd2[4:0]))))
        else $error("table result wrong");

    fc_result_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s.state == RMCE_EXEC && s.op == `RMCE_MODE_FREQ_CNT) |=>
        {s.res3, s.res2, s.res1} == $past(s.fc_latch))
        else $error("frequency result wrong");

    fc_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        gate_tick |=> (s.fc_latch == $past(s.fc_cnt)) &&
        (s.gate_cnt == 32'(FC_GATE_CYC - 1)))
        else $error("frequency gate wrong");

    fc_count_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (am_edge_i && !gate_tick && s.fc_cnt != 24'hFFFFFF) |=>
        s.fc_cnt == $past(s.fc_cnt) + 24'h000001)
        else $error("frequency edge not counted");

    tc_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr && idx == `RMCE_IDX_AGC_CTL) |=>
        (dgl_tc_sel_o == $past(pwdata_i[2:0])) &&
        (discrete_agc_tc_sel_o == dgl_tc_sel_o))
        else $error("time constant select wrong");

    tc_prog_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s.state == RMCE_EXEC && s.op == `RMCE_MODE_CUSTOM_TC &&
         s.arg == 8'h01) |=> s.tc_mult[0] == $past(mult_in))
        else $error("custom time constant not stored");

    mode_mirror_a: assert property (@(posedge mclk_i)
        disable iff (rst_i) (rd_setup && mapped && idx == `RMCE_IDX_MODE)
        |=> prdata_o[7:0] == {$past(mode), 2'b00, $past(busy_o)})
        else $error("mode status not mirrored");

    exec_short_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        s.state == RMCE_EXEC |=>
        s.state == RMCE_IDLE)
        else $error("command held in execute");

    op_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        trig_ok |=>
        (s.op == $past(mode)) && (s.arg == $past(pwdata_i[7:0])))
        else $error("command code not taken");

    bad_mode_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr && idx == `RMCE_IDX_WORD1 && !is_cmd_mode(mode)) |=>
        s.state == RMCE_IDLE)
        else $error("trigger in foreign mode taken");

    gain_take_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        gain_trig |=>
        gif.go && (gif.cmd == $past(pwdata_i[1:0])))
        else $error("gain command not launched");

    gain_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr && idx == `RMCE_IDX_GAIN_CTL && busy_o) |=>
        !gif.go)
        else $error("gain update taken while busy");

    res_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !busy_o |=>
        $stable({s.res3, s.res2, s.res1}))
        else $error("results changed while idle");

    tc_fixed_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        s.agc_ctl[2:0] < `RMCE_CUSTOM_TC_BASE |->
        agc_tc_mult_o == 16'h0000)
        else $error("fixed slot shows a multiplier");

    tc_pick_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        s.agc_ctl[2:0] >= `RMCE_CUSTOM_TC_BASE |-> agc_tc_mult_o ==
        s.tc_mult[2'(s.agc_ctl[2:0] - `RMCE_CUSTOM_TC_BASE)])
        else $error("custom slot multiplier wrong");

    tc_nonzero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s.state == RMCE_EXEC && s.op == `RMCE_MODE_CUSTOM_TC &&
         s.arg != 8'h00 && s.arg <= `RMCE_CUSTOM_DES_MAX) |=>
        s.tc_mult[$past(slot)] != 16'h0000)
        else $error("zero multiplier stored");

    tc_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (s.state == RMCE_EXEC && s.op == `RMCE_MODE_CUSTOM_TC &&
         (s.arg == 8'h00 || s.arg > `RMCE_CUSTOM_DES_MAX)) |=>
        s.tc_mult == $past(s.tc_mult))
        else $error("bad designator changed a slot");

    gate_step_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !gate_tick |=>
        s.gate_cnt == $past(s.gate_cnt) - 32'h1)
        else $error("gate counter skipped");

    gain_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_setup && mapped && idx == `RMCE_IDX_GAIN_CTL) |=>
        prdata_o == {24'h000000, $past(s.gain_ctl)})
        else $error("gain register read wrong");

endmodule
